// ---- rtl/bscan_consts.svh ----
// Constants for the boundary-scan test port and its configuration interlock.
// Assumes inclusion by the port module and the testbench by bare name.
`ifndef BSCAN_CONSTS_SVH
`define BSCAN_CONSTS_SVH
`define IR_LEN 10
`define IR_CAPTURE 10'h2AA
`define IR_EXTEST 10'h00F
`define IR_SAMPLE 10'h005
`define IR_BYPASS 10'h3FF
`define IR_IDCODE 10'h006
`define IR_USERCODE 10'h007
`define IR_CLAMP 10'h00A
`define IR_HIGHZ 10'h00B
`define IR_CONFIG_IO 10'h00D
`define IR_PULSE_CFG 10'h001
// The identification value is arbitrary and names no real part.
`define ID_CODE 32'h1234_5001
`define USER_DEFAULT 32'hFFFF_FFFF
`endif

// ---- rtl/bscan_pkg.sv ----
// Types for the boundary-scan test port.
// Assumes the constants header defines the instruction codes.
package bscan_pkg;
	typedef enum logic [3:0] {
		TL_RESET = 4'h0, IDLE = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
		UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
		EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
	} tap_state_t;
endpackage : bscan_pkg

// ---- rtl/sync2.sv ----
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a pin; only the second flop is read.
`timescale 1ns/10ps
module sync2 (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic d_i,
	output logic q_o
);
	typedef struct packed {
		logic meta;
		logic q;
	} sync_st_t;
	sync_st_t st_reg, st_next;
	always_comb begin
		st_next.meta = d_i;
		st_next.q = st_reg.meta;
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign q_o = st_reg.q;
endmodule : sync2

// ---- rtl/bscan_port.sv ----
// Boundary-scan test access port with configuration interlock.
// Assumes test pins are asynchronous and sampled by clk_sys_i at 10 MHz.
`timescale 1ns/10ps
`include "bscan_consts.svh"
module bscan_port #(
	parameter int NPINS = 4,
	parameter logic [NPINS-1:0] DIFF_MASK = 4'h3
) (
	// System.
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Test pins.
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// Configuration engine.
	input wire logic cfg_busy_i,
	input wire logic cfg_done_i,
	input wire logic [31:0] usercode_i,
	output logic cfg_abort_o,
	output logic cfg_restart_o,
	// Device pins.
	input wire logic [NPINS-1:0] core_out_i,
	input wire logic [NPINS-1:0] core_oe_i,
	input wire logic [NPINS-1:0] pin_in_i,
	output logic [NPINS-1:0] pin_out_o,
	output logic [NPINS-1:0] pin_oe_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int BSR = 2 * NPINS;
	typedef struct packed {
		bscan_pkg::tap_state_t tap;
		logic tck_d;
		logic [`IR_LEN-1:0] ir_sh;
		logic [`IR_LEN-1:0] ir;
		logic [31:0] id_sh;
		logic byp;
		logic [BSR-1:0] bs_sh;
		logic [BSR-1:0] bs_up;
		logic cfg_held;
		logic tdo;
		logic tdo_oe;
		logic abort;
		logic restart;
		logic [NPINS-1:0] pout;
		logic [NPINS-1:0] poe;
	} port_st_t;
	port_st_t st_reg, st_next;
	logic tck_s, tms_s, tdi_s;
	sync2 u_tck (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .d_i(tck_i),
		.q_o(tck_s));
	sync2 u_tms (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .d_i(tms_i),
		.q_o(tms_s));
	sync2 u_tdi (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .d_i(tdi_i),
		.q_o(tdi_s));
	// Pin levels come from the board, so they are synchronised too.
	logic [NPINS-1:0] pin_in_s;
	for (genvar g = 0; g < NPINS; g++) begin : g_pin_sync
		sync2 u_pin (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
			.d_i(pin_in_i[g]), .q_o(pin_in_s[g]));
	end
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic rise, fall, ext_mode, safe_ir, held_now;
	logic [`IR_LEN-1:0] ir_eff;
	logic [BSR-1:0] cap_v;
	always_comb begin
		st_next = st_reg;
		rise = tck_s && !st_reg.tck_d;
		fall = !tck_s && st_reg.tck_d;
		st_next.tck_d = tck_s;
		st_next.abort = 1'b0;
		st_next.restart = 1'b0;
		// External test is refused while configuration runs unaborted.
		held_now = st_reg.cfg_held;
		safe_ir = (st_reg.ir == `IR_BYPASS) || (st_reg.ir == `IR_IDCODE)
			|| (st_reg.ir == `IR_SAMPLE);
		ir_eff = (cfg_busy_i && !held_now && !safe_ir) ? `IR_BYPASS
			: st_reg.ir;
		ext_mode = (ir_eff == `IR_EXTEST);
		cap_v = {core_oe_i, pin_in_s};
		if (rise) begin
			case (st_reg.tap)
			bscan_pkg::TL_RESET: st_next.tap = tms_s ? bscan_pkg::TL_RESET
				: bscan_pkg::IDLE;
			bscan_pkg::IDLE: st_next.tap = tms_s ? bscan_pkg::SEL_DR
				: bscan_pkg::IDLE;
			bscan_pkg::SEL_DR: st_next.tap = tms_s ? bscan_pkg::SEL_IR
				: bscan_pkg::CAP_DR;
			bscan_pkg::CAP_DR: st_next.tap = tms_s ? bscan_pkg::EX1_DR
				: bscan_pkg::SH_DR;
			bscan_pkg::SH_DR: st_next.tap = tms_s ? bscan_pkg::EX1_DR
				: bscan_pkg::SH_DR;
			bscan_pkg::EX1_DR: st_next.tap = tms_s ? bscan_pkg::UPD_DR
				: bscan_pkg::PAU_DR;
			bscan_pkg::PAU_DR: st_next.tap = tms_s ? bscan_pkg::EX2_DR
				: bscan_pkg::PAU_DR;
			bscan_pkg::EX2_DR: st_next.tap = tms_s ? bscan_pkg::UPD_DR
				: bscan_pkg::SH_DR;
			bscan_pkg::UPD_DR: st_next.tap = tms_s ? bscan_pkg::SEL_DR
				: bscan_pkg::IDLE;
			bscan_pkg::SEL_IR: st_next.tap = tms_s ? bscan_pkg::TL_RESET
				: bscan_pkg::CAP_IR;
			bscan_pkg::CAP_IR: st_next.tap = tms_s ? bscan_pkg::EX1_IR
				: bscan_pkg::SH_IR;
			bscan_pkg::SH_IR: st_next.tap = tms_s ? bscan_pkg::EX1_IR
				: bscan_pkg::SH_IR;
			bscan_pkg::EX1_IR: st_next.tap = tms_s ? bscan_pkg::UPD_IR
				: bscan_pkg::PAU_IR;
			bscan_pkg::PAU_IR: st_next.tap = tms_s ? bscan_pkg::EX2_IR
				: bscan_pkg::PAU_IR;
			bscan_pkg::EX2_IR: st_next.tap = tms_s ? bscan_pkg::UPD_IR
				: bscan_pkg::SH_IR;
			default: st_next.tap = tms_s ? bscan_pkg::SEL_DR
				: bscan_pkg::IDLE;
			endcase
			case (st_reg.tap)
			bscan_pkg::CAP_IR: st_next.ir_sh = `IR_CAPTURE;
			bscan_pkg::SH_IR: st_next.ir_sh = {tdi_s,
				st_reg.ir_sh[`IR_LEN-1:1]};
			bscan_pkg::CAP_DR: begin
				st_next.byp = 1'b0;
				st_next.id_sh = (ir_eff == `IR_USERCODE)
					? (cfg_done_i ? usercode_i : `USER_DEFAULT)
					: `ID_CODE;
				if ((ir_eff == `IR_SAMPLE) || ext_mode) begin
					st_next.bs_sh = cap_v;
				end
			end
			bscan_pkg::SH_DR: begin
				st_next.byp = tdi_s;
				st_next.id_sh = {tdi_s, st_reg.id_sh[31:1]};
				if ((ir_eff == `IR_SAMPLE) || ext_mode) begin
					st_next.bs_sh = {tdi_s, st_reg.bs_sh[BSR-1:1]};
				end
			end
			bscan_pkg::UPD_DR: begin
				if ((ir_eff == `IR_SAMPLE) || ext_mode) begin
					st_next.bs_up = st_reg.bs_sh;
				end
			end
			bscan_pkg::UPD_IR: begin
				st_next.ir = st_reg.ir_sh;
				if (st_reg.ir_sh == `IR_CONFIG_IO) begin
					st_next.abort = cfg_busy_i;
					st_next.cfg_held = 1'b1;
				end
				if (st_reg.ir_sh == `IR_PULSE_CFG) begin
					st_next.restart = 1'b1;
					st_next.cfg_held = 1'b0;
				end
			end
			default: st_next.ir = st_reg.ir;
			endcase
			if (st_reg.tap == bscan_pkg::TL_RESET && tms_s) begin
				st_next.ir = `IR_IDCODE;
			end
		end
		if (fall) begin
			st_next.tdo_oe = (st_reg.tap == bscan_pkg::SH_IR)
				|| (st_reg.tap == bscan_pkg::SH_DR);
			if (st_reg.tap == bscan_pkg::SH_IR) begin
				st_next.tdo = st_reg.ir_sh[0];
			end else if (ir_eff == `IR_IDCODE || ir_eff == `IR_USERCODE) begin
				st_next.tdo = st_reg.id_sh[0];
			end else if (ir_eff == `IR_SAMPLE || ext_mode) begin
				st_next.tdo = st_reg.bs_sh[0];
			end else begin
				st_next.tdo = st_reg.byp;
			end
		end
		// Pin drive: enable cell zero means drive in external test.
		for (int i = 0; i < NPINS; i++) begin
			if (cfg_done_i && DIFF_MASK[i]) begin
				st_next.pout[i] = core_out_i[i];
				st_next.poe[i] = core_oe_i[i];
			end else if (ext_mode || ir_eff == `IR_CLAMP) begin
				st_next.pout[i] = st_reg.bs_up[i];
				st_next.poe[i] = !st_reg.bs_up[NPINS+i];
			end else if (ir_eff == `IR_HIGHZ) begin
				st_next.pout[i] = 1'b0;
				st_next.poe[i] = 1'b0;
			end else begin
				st_next.pout[i] = core_out_i[i];
				st_next.poe[i] = core_oe_i[i];
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '0;
			st_reg.ir <= `IR_IDCODE;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tdo_o = st_reg.tdo;
	assign tdo_oe_o = st_reg.tdo_oe;
	assign cfg_abort_o = st_reg.abort;
	assign cfg_restart_o = st_reg.restart;
	assign pin_out_o = st_reg.pout;
	assign pin_oe_o = st_reg.poe;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	extest_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(ext_mode && !cfg_done_i)
		|=> (pin_oe_o == ~$past(st_reg.bs_up[BSR-1:NPINS])))
		else $error("External test pin enable wrong.");
	busy_block_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(cfg_busy_i && !st_reg.cfg_held)
		|=> (pin_out_o == $past(core_out_i) && pin_oe_o == $past(core_oe_i)))
		else $error("External test active during configuration.");
	abort_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cfg_abort_o |=> !cfg_abort_o)
		else $error("Abort pulse longer than one cycle.");
	restart_load_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cfg_restart_o |-> st_reg.ir == `IR_PULSE_CFG)
		else $error("Restart without pulse instruction.");
	ir_capture_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(rise && st_reg.tap == bscan_pkg::CAP_IR) |=> st_reg.ir_sh == `IR_CAPTURE)
		else $error("Capture pattern not loaded.");
	tap_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(rise && tms_s && st_reg.tap == bscan_pkg::SEL_IR)
		|=> st_reg.tap == bscan_pkg::TL_RESET)
		else $error("Select-IR with mode high missed reset.");
	diff_internal_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(cfg_done_i && DIFF_MASK[0]) |=> pin_oe_o[0] == $past(core_oe_i[0]))
		else $error("Differential pin under scan control.");
	safe_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(cfg_busy_i && st_reg.ir == `IR_IDCODE && fall
		&& st_reg.tap == bscan_pkg::SH_DR) |=> tdo_o == $past(st_reg.id_sh[0]))
		else $error("Identification blocked during configuration.");
endmodule : bscan_port

// ---- dv/jtag_tester.sv ----
// Behavioural boundary-scan tester that drives the test pins.
// Assumes a 100 ns system clock; one test-clock period spans 8 of them.
`timescale 1ns/10ps
module jtag_tester (
	// System.
	input wire logic clk_sys_i,
	// Test pins.
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	logic smp;
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// Output is taken late in the high phase, well after the port's
	// synchronised falling-edge update has settled.
	task automatic tick(input logic m, input logic d);
		tck_o = 1'b0;
		tms_o = m;
		tdi_o = d;
		repeat (4) @(negedge clk_sys_i);
		tck_o = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		smp = tdo_i;
	endtask : tick
	// The clock is parked low between frames, as a real tester does.
	task automatic go_reset();
		repeat (5) tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tck_o = 1'b0;
		@(negedge clk_sys_i);
	endtask : go_reset
	task automatic shift(input logic ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		dout = '0;
		tick(1'b1, 1'b1);
		if (ir)
			tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tick(1'b0, 1'b1);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i]);
			dout[i] = smp;
		end
		tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tck_o = 1'b0;
		@(negedge clk_sys_i);
	endtask : shift
endmodule : jtag_tester

// ---- dv/testbench.sv ----
// Self-checking bench for the boundary-scan port and its interlock.
// Assumes the tester model and the configuration engine are modelled here.
`timescale 1ns/10ps
`include "bscan_consts.svh"
`define CHK(nm, e, g) \
	checked++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, g); \
	end
module testbench;
	logic clk_sys_i, rstn_i, tck, tms, tdi, tdo;
	logic cfg_busy, cfg_done, cfg_abort, cfg_restart, tdo_oe;
	logic [31:0] usercode, d;
	logic [3:0] core_out, core_oe, pin_in, pin_out, pin_oe;
	int n_errors, checked, n_abort, n_restart, n_oe;
	bscan_port u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
		.tdo_oe_o(tdo_oe), .cfg_busy_i(cfg_busy), .cfg_done_i(cfg_done),
		.usercode_i(usercode), .cfg_abort_o(cfg_abort),
		.cfg_restart_o(cfg_restart), .core_out_i(core_out),
		.core_oe_i(core_oe), .pin_in_i(pin_in), .pin_out_o(pin_out),
		.pin_oe_o(pin_oe));
	jtag_tester u_tst (.clk_sys_i(clk_sys_i), .tdo_i(tdo), .tck_o(tck),
		.tms_o(tms), .tdi_o(tdi));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// Abort and restart pulses stand one cycle, so each high sample is one event; tdo_oe is a level and only shows it was seen.
	always @(posedge clk_sys_i) begin
		if (cfg_abort === 1'b1)
			n_abort++;
		if (cfg_restart === 1'b1)
			n_restart++;
		if (tdo_oe === 1'b1)
			n_oe++;
	end
	task automatic ir(input logic [9:0] c);
		u_tst.shift(1'b1, 10, {22'h0, c}, d);
	endtask : ir
	task automatic dr(input int n, input logic [31:0] v);
		u_tst.shift(1'b0, n, v, d);
	endtask : dr
	task automatic t_capture();
		u_tst.go_reset();
		ir(`IR_IDCODE);
		`CHK("ir_capture", `IR_CAPTURE, d[9:0])
		`CHK("tdo_oe_seen", 1'b1, n_oe > 0)
		`CHK("tdo_oe_idle", 1'b0, tdo_oe)
		dr(32, 32'h0);
		`CHK("idcode", `ID_CODE, d)
	endtask : t_capture
	// Cells are preset before external test so no pin contends.
	task automatic t_extest();
		ir(`IR_SAMPLE);
		dr(8, 32'h5A);
		`CHK("sample_cap", 8'hF9, d[7:0])
		ir(`IR_EXTEST);
		`CHK("ext_data", 4'hA, pin_out)
		`CHK("ext_oe", 4'hA, pin_oe)
		cfg_done = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		`CHK("diff_data", 4'h9, pin_out)
		`CHK("diff_oe", 4'hB, pin_oe)
	endtask : t_extest
	task automatic t_user();
		usercode = 32'hC0DE_0042;
		ir(`IR_USERCODE);
		dr(32, 32'h0);
		`CHK("usercode", 32'hC0DE_0042, d)
		ir(`IR_HIGHZ);
		// Configured differential pins stay with the core in high impedance.
		`CHK("highz_oe", 4'h3, pin_oe)
		ir(`IR_CLAMP);
		`CHK("clamp_data", 4'h9, pin_out)
		`CHK("clamp_oe", 4'hB, pin_oe)
		ir(`IR_BYPASS);
		dr(2, 32'h1);
		`CHK("bypass", 2'b10, d[1:0])
	endtask : t_user
	// External test while configuring must fall back to bypass.
	task automatic t_busy();
		cfg_done = 1'b0;
		cfg_busy = 1'b1;
		ir(`IR_EXTEST);
		`CHK("busy_pins", core_out, pin_out)
		dr(2, 32'h1);
		`CHK("busy_bypass", 2'b10, d[1:0])
		ir(`IR_IDCODE);
		dr(32, 32'h0);
		`CHK("busy_idcode", `ID_CODE, d)
		`CHK("no_abort", 0, n_abort)
	endtask : t_busy
	task automatic t_cfgio();
		ir(`IR_CONFIG_IO);
		`CHK("abort", 1, n_abort)
		ir(`IR_EXTEST);
		`CHK("held_pins", 4'hA, pin_out)
		ir(`IR_PULSE_CFG);
		`CHK("restart", 1, n_restart)
		cfg_busy = 1'b0;
	endtask : t_cfgio
	task automatic test_done();
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		rstn_i = 1'b0;
		// The busy input starts low, so configuration is idle until t_busy.
		cfg_busy = 1'b0;
		cfg_done = 1'b0;
		usercode = 32'h0;
		core_out = 4'h5;
		core_oe = 4'hF;
		pin_in = 4'h9;
		repeat (4) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		t_capture();
		t_extest();
		t_user();
		t_busy();
		t_cfgio();
		test_done();
	end
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		n_errors++;
		test_done();
	end
endmodule : testbench
